// ==== verilog/ipm_mapper.sv ====
// APB-programmable mapper from seven input terminals to drive control functions.
//
// Local design decisions: the APB register port and the address map.
`timescale 1ns/1ps
module ipm_mapper #(
  parameter int NUM_PINS = ipm_pkg::NUM_PINS,
  parameter int FILTER   = ipm_pkg::FILTER_CYC
) (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [NUM_PINS-1:0] pin_in,
  output ipm_pkg::ipm_func_s       func,
  output ipm_pkg::ipm_speed_s      speed
);

  localparam int SEL_FLAT_W = NUM_PINS * ipm_pkg::CODE_W;

  initial begin
    if (NUM_PINS != ipm_pkg::NUM_PINS) begin
      $error("The register map serves exactly seven pins.");
    end
    if (FILTER + ipm_pkg::PATH_CYC >= ipm_pkg::FAST_RESP_CYC) begin
      $error("Input filter too long for the fast response bound.");
    end
    if (FILTER < 1) begin
      $error("The input filter needs at least one cycle.");
    end
    if (ipm_pkg::CODE_W != 16) begin
      $error("Selectors are sliced as sixteen-bit codes.");
    end
    if ($bits(ipm_pkg::ipm_func_s) > 32) begin
      $error("The function status must fit one bus word.");
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Code legality per pin.

  function automatic logic code_ok(input logic [15:0] code, input int pin);
    logic ok;
    ok = 1'b0;
    case (code)
      ipm_pkg::CODE_LOW,
      ipm_pkg::CODE_MIDDLE,
      ipm_pkg::CODE_HIGH,
      ipm_pkg::CODE_SECOND,
      ipm_pkg::CODE_CUR4,
      ipm_pkg::CODE_JOG,
      ipm_pkg::CODE_HEAT,
      ipm_pkg::CODE_EXTRA,
      ipm_pkg::CODE_RUN_EN,
      ipm_pkg::CODE_LOCKOUT,
      ipm_pkg::CODE_PID,
      ipm_pkg::CODE_BRAKE,
      ipm_pkg::CODE_PANEL_EXT,
      ipm_pkg::CODE_VF,
      ipm_pkg::CODE_SHUTOFF,
      ipm_pkg::CODE_SELFHOLD,
      ipm_pkg::CODE_CLEAR,
      ipm_pkg::CODE_PANEL_NET,
      ipm_pkg::CODE_EXT_NET,
      ipm_pkg::CODE_SRC,
      ipm_pkg::CODE_NONE: begin
        ok = 1'b1;
      end
      ipm_pkg::CODE_FORWARD: begin
        ok = (pin == 0);
      end
      ipm_pkg::CODE_REVERSE: begin
        ok = (pin == 1);
      end
      default: begin
        ok = 1'b0;
      end
    endcase
    return ok;
  endfunction : code_ok

  // ORs together every pin whose selector holds the given code.
  function automatic logic any_hit(input logic [15:0]           code,
                                   input logic [SEL_FLAT_W-1:0] sel,
                                   input logic [NUM_PINS-1:0]   lvl);
    logic hit;
    hit = 1'b0;
    for (int p = 0; p < NUM_PINS; p++) begin
      hit = hit | ((sel[p*16 +: 16] == code) & lvl[p]);
    end
    return hit;
  endfunction : any_hit

  ////////////////////////////////////////////////////////////////////////////
  // Input terminals.

  logic [NUM_PINS-1:0] pin_lvl;

  // Every pin has its own filter of one short length, inside the 2 ms bound of the fastest signals.
  for (genvar g = 0; g < NUM_PINS; g++) begin : g_pin
    ipm_pin_filter #(
      .FILTER  (FILTER)
    ) u_filter (
      .pclk    (pclk),
      .presetn (presetn),
      .pin_raw (pin_in[g]),
      .level_q (pin_lvl[g])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [SEL_FLAT_W-1:0] sel_q;
  logic [1:0]            remote_sel_q;
  logic                  stop_sel_q;
  logic [31:0]           prdata_q;
  logic                  pready_q;
  logic                  pslverr_q;
  ipm_pkg::ipm_func_s    func_q;
  ipm_pkg::ipm_func_s    func_d;
  ipm_pkg::ipm_speed_s   speed_q;
  ipm_pkg::ipm_speed_s   speed_d;

  ////////////////////////////////////////////////////////////////////////////
  // APB decode.

  wire        setup_ph   = psel & ~penable;
  wire        commit     = psel & penable & pready_q;
  wire [2:0]  sel_idx    = paddr[4:2];
  wire        word_ok    = (paddr[1:0] == 2'b00);
  wire        hit_sel    = word_ok & (paddr <= ipm_pkg::OFS_CLEAR_PIN);
  wire        hit_remote = (paddr == ipm_pkg::OFS_REMOTE_SEL);
  wire        hit_stop   = (paddr == ipm_pkg::OFS_STOP_SEL);
  wire        hit_pins   = (paddr == ipm_pkg::OFS_PIN_STATUS);
  wire        hit_funcs  = (paddr == ipm_pkg::OFS_FUNC_STATUS);
  wire        mapped     = hit_sel | hit_remote | hit_stop | hit_pins | hit_funcs;
  wire        hi_zero    = (pwdata[31:16] == 16'h0000);
  wire        sel_ok     = hi_zero & code_ok(pwdata[15:0], int'(sel_idx));
  wire        remote_ok  = (pwdata[31:2] == 30'h0) & (pwdata[1:0] <= ipm_pkg::REMOTE_SEL_MAX);
  wire        stop_ok    = (pwdata[31:1] == 31'h0);
  wire        wr_bad     = pwrite & ((hit_sel & ~sel_ok) | (hit_remote & ~remote_ok) |
                                     (hit_stop & ~stop_ok) | hit_pins | hit_funcs);
  wire        err_d      = ~mapped | wr_bad;
  wire        wr_sel     = commit & pwrite & hit_sel & sel_ok;
  wire        wr_remote  = commit & pwrite & hit_remote & remote_ok;
  wire        wr_stop    = commit & pwrite & hit_stop & stop_ok;

  wire [31:0] rd_word =
      hit_sel    ? {16'h0000, sel_q[int'(sel_idx)*16 +: 16]} :
      hit_remote ? {30'h0, remote_sel_q} :
      hit_stop   ? {31'h0, stop_sel_q} :
      hit_pins   ? {{(32-NUM_PINS){1'b0}}, pin_lvl} :
      hit_funcs  ? {{(32-$bits(ipm_pkg::ipm_func_s)){1'b0}}, func_q} :
                   32'h0000_0000;

  // Answers in the first access cycle; data and error are prepared in setup.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= setup_ph;
      pslverr_q <= setup_ph & err_d;
      if (setup_ph) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_word;
      end
    end
  end

  // Selector and mode registers; a rejected write leaves them untouched.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_q        <= ipm_pkg::RST_SEL_FLAT;
      remote_sel_q <= ipm_pkg::RST_REMOTE_SEL;
      stop_sel_q   <= ipm_pkg::RST_STOP_SEL;
    end else begin
      if (wr_sel) begin
        sel_q[int'(sel_idx)*16 +: 16] <= pwdata[15:0];
      end
      if (wr_remote) begin
        remote_sel_q <= pwdata[1:0];
      end
      if (wr_stop) begin
        stop_sel_q <= pwdata[0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Function decode.

  wire remote_on   = (remote_sel_q != 2'h0);
  wire stop_on     = stop_sel_q;

  // These wires decode the direction and trip clear codes.
  wire c_fwd       = any_hit(ipm_pkg::CODE_FORWARD, sel_q, pin_lvl);
  wire c_rev       = any_hit(ipm_pkg::CODE_REVERSE, sel_q, pin_lvl);
  wire c_clear     = any_hit(ipm_pkg::CODE_CLEAR, sel_q, pin_lvl);

  // The low, middle and high codes also carry the remote meanings, the low and second codes the stop-on meanings; the extra code neither.
  wire c_low       = any_hit(ipm_pkg::CODE_LOW, sel_q, pin_lvl);
  wire c_mid       = any_hit(ipm_pkg::CODE_MIDDLE, sel_q, pin_lvl);
  wire c_high      = any_hit(ipm_pkg::CODE_HIGH, sel_q, pin_lvl);
  wire c_second    = any_hit(ipm_pkg::CODE_SECOND, sel_q, pin_lvl);
  wire c_extra     = any_hit(ipm_pkg::CODE_EXTRA, sel_q, pin_lvl);

  // These wires decode the speed source and analog input codes.
  wire c_cur4      = any_hit(ipm_pkg::CODE_CUR4, sel_q, pin_lvl);
  wire c_jog       = any_hit(ipm_pkg::CODE_JOG, sel_q, pin_lvl);
  wire c_pid       = any_hit(ipm_pkg::CODE_PID, sel_q, pin_lvl);

  // These wires decode the enable, shutoff and interlock codes.
  wire c_run_en    = any_hit(ipm_pkg::CODE_RUN_EN, sel_q, pin_lvl);
  wire c_shutoff   = any_hit(ipm_pkg::CODE_SHUTOFF, sel_q, pin_lvl);
  wire c_lockout   = any_hit(ipm_pkg::CODE_LOCKOUT, sel_q, pin_lvl);
  wire c_brake     = any_hit(ipm_pkg::CODE_BRAKE, sel_q, pin_lvl);
  wire c_selfhold  = any_hit(ipm_pkg::CODE_SELFHOLD, sel_q, pin_lvl);

  // These wires decode the operation place and control method codes.
  wire c_panel_ext = any_hit(ipm_pkg::CODE_PANEL_EXT, sel_q, pin_lvl);
  wire c_vf        = any_hit(ipm_pkg::CODE_VF, sel_q, pin_lvl);
  wire c_panel_net = any_hit(ipm_pkg::CODE_PANEL_NET, sel_q, pin_lvl);
  wire c_ext_net   = any_hit(ipm_pkg::CODE_EXT_NET, sel_q, pin_lvl);
  wire c_src       = any_hit(ipm_pkg::CODE_SRC, sel_q, pin_lvl);

  // The thermal relay contact is normally closed, so an open contact is the trip.
  wire c_heat      = any_hit(ipm_pkg::CODE_HEAT, sel_q, ~pin_lvl);

  always_comb begin
    func_d = '0;
    func_d.forward_run_command     = c_fwd;
    func_d.reverse_run_command     = c_rev;
    func_d.trip_clear_input        = c_clear;

    // Stop-on contact takes code 0 before the remote and speed meanings.
    func_d.stop_contact_0          = stop_on & c_low;
    func_d.stop_contact_1          = stop_on & c_second;

    func_d.low_speed_select        = ~stop_on & ~remote_on & c_low;
    func_d.middle_speed_select     = ~remote_on & c_mid;
    func_d.high_speed_select       = ~remote_on & c_high;

    func_d.remote_setting_clear    = ~stop_on & remote_on & c_low;
    func_d.remote_decelerate       = remote_on & c_mid;
    func_d.remote_accelerate       = remote_on & c_high;

    func_d.second_parameter_set    = ~stop_on & c_second;
    func_d.extra_speed_bit         = c_extra;

    func_d.current_input_4_select  = c_cur4;
    func_d.jog_select              = c_jog;
    func_d.pid_enable              = c_pid;

    func_d.motor_heat_trip         = c_heat;
    func_d.supply_unit_run_enable  = c_run_en;
    func_d.output_shutoff_input    = c_shutoff;
    func_d.panel_mode_lockout      = c_lockout;
    func_d.brake_open_done         = c_brake;
    func_d.start_self_hold         = c_selfhold;

    func_d.external_operation      = c_panel_ext;
    func_d.vf_control_switch       = c_vf;
    func_d.panel_network_switch    = c_panel_net;
    func_d.external_network_switch = c_ext_net;
    func_d.command_source_switch   = c_src;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Speed command arbitration.

  wire [3:0] preset_bits = {func_d.extra_speed_bit, func_d.high_speed_select,
                            func_d.middle_speed_select, func_d.low_speed_select};
  wire       preset_on   = (preset_bits != 4'h0);

  always_comb begin
    speed_d = '0;
    if (func_d.jog_select) begin
      speed_d.src = ipm_pkg::IPM_SRC_JOG;
    end else if (preset_on) begin
      speed_d.src          = ipm_pkg::IPM_SRC_PRESET;
      speed_d.preset_index = preset_bits;
    end else if (func_d.pid_enable) begin
      speed_d.src = ipm_pkg::IPM_SRC_PID;
    end else begin
      speed_d.src = ipm_pkg::IPM_SRC_NONE;
    end
  end

  // Function outputs are registered one cycle after the filtered pins.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      func_q  <= '0;
      speed_q <= '0;
    end else begin
      func_q  <= func_d;
      speed_q <= speed_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs.

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;
  assign func    = func_q;
  assign speed   = speed_q;

endmodule : ipm_mapper

// ==== verilog/ipm_pkg.sv ====
// Constants, register map and carrier types of the input pin function mapper.
package ipm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int          NUM_PINS      = 7;
  localparam int          CODE_W        = 16;
  localparam int          ADDR_W        = 8;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] CODE_LOW      = 16'h0000;
  localparam logic [15:0] CODE_MIDDLE   = 16'h0001;
  localparam logic [15:0] CODE_HIGH     = 16'h0002;
  localparam logic [15:0] CODE_SECOND   = 16'h0003;
  localparam logic [15:0] CODE_CUR4     = 16'h0004;
  localparam logic [15:0] CODE_JOG      = 16'h0005;
  localparam logic [15:0] CODE_HEAT     = 16'h0007;
  localparam logic [15:0] CODE_EXTRA    = 16'h0008;
  localparam logic [15:0] CODE_RUN_EN   = 16'h000A;
  localparam logic [15:0] CODE_LOCKOUT  = 16'h000C;
  localparam logic [15:0] CODE_PID      = 16'h000E;
  localparam logic [15:0] CODE_BRAKE    = 16'h000F;
  localparam logic [15:0] CODE_PANEL_EXT = 16'h0010;
  localparam logic [15:0] CODE_VF       = 16'h0012;
  localparam logic [15:0] CODE_SHUTOFF  = 16'h0018;
  localparam logic [15:0] CODE_SELFHOLD = 16'h0019;
  localparam logic [15:0] CODE_FORWARD  = 16'h003C;
  localparam logic [15:0] CODE_REVERSE  = 16'h003D;
  localparam logic [15:0] CODE_CLEAR    = 16'h003E;
  localparam logic [15:0] CODE_PANEL_NET = 16'h0041;
  localparam logic [15:0] CODE_EXT_NET  = 16'h0042;
  localparam logic [15:0] CODE_SRC      = 16'h0043;
  localparam logic [15:0] CODE_NONE     = 16'h270F;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [15:0] RST_FORWARD_PIN  = 16'h003C;
  localparam logic [15:0] RST_REVERSE_PIN  = 16'h003D;
  localparam logic [15:0] RST_LOW_PIN      = 16'h0000;
  localparam logic [15:0] RST_MIDDLE_PIN   = 16'h0001;
  localparam logic [15:0] RST_HIGH_PIN     = 16'h0002;
  localparam logic [15:0] RST_SHUTOFF_PIN  = 16'h0018;
  localparam logic [15:0] RST_CLEAR_PIN    = 16'h003E;
  localparam logic [NUM_PINS*16-1:0] RST_SEL_FLAT = {RST_CLEAR_PIN, RST_SHUTOFF_PIN,
    RST_HIGH_PIN, RST_MIDDLE_PIN, RST_LOW_PIN, RST_REVERSE_PIN, RST_FORWARD_PIN};
  localparam logic [1:0]  RST_REMOTE_SEL   = 2'h0;
  localparam logic [1:0]  REMOTE_SEL_MAX   = 2'h2;
  localparam logic        RST_STOP_SEL     = 1'h0;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0]  OFS_FORWARD_PIN  = 8'h00;
  localparam logic [7:0]  OFS_REVERSE_PIN  = 8'h04;
  localparam logic [7:0]  OFS_LOW_PIN      = 8'h08;
  localparam logic [7:0]  OFS_MIDDLE_PIN   = 8'h0C;
  localparam logic [7:0]  OFS_HIGH_PIN     = 8'h10;
  localparam logic [7:0]  OFS_SHUTOFF_PIN  = 8'h14;
  localparam logic [7:0]  OFS_CLEAR_PIN    = 8'h18;
  localparam logic [7:0]  OFS_REMOTE_SEL   = 8'h1C;
  localparam logic [7:0]  OFS_STOP_SEL     = 8'h20;
  localparam logic [7:0]  OFS_PIN_STATUS   = 8'h24;
  localparam logic [7:0]  OFS_FUNC_STATUS  = 8'h28;

  ////////////////////////////////////////////////////////////////////////////
  localparam int          CLK_HZ           = 25_000_000;
  localparam int          FAST_RESP_US     = 2_000;
  localparam int          SLOW_RESP_US     = 20_000;
  localparam int          FAST_RESP_CYC    = FAST_RESP_US * (CLK_HZ / 1_000_000);
  localparam int          SLOW_RESP_CYC    = SLOW_RESP_US * (CLK_HZ / 1_000_000);
  localparam int          FILTER_CYC       = 8;
  localparam int          PATH_CYC         = 4;

  ////////////////////////////////////////////////////////////////////////////
  typedef enum logic [1:0] {
    IPM_SRC_NONE   = 2'b00,
    IPM_SRC_JOG    = 2'b01,
    IPM_SRC_PRESET = 2'b10,
    IPM_SRC_PID    = 2'b11
  } ipm_speed_src_e;

  typedef struct packed {
    logic           forward_run_command;
    logic           reverse_run_command;
    logic           low_speed_select;
    logic           middle_speed_select;
    logic           high_speed_select;
    logic           remote_setting_clear;
    logic           remote_decelerate;
    logic           remote_accelerate;
    logic           stop_contact_0;
    logic           stop_contact_1;
    logic           second_parameter_set;
    logic           current_input_4_select;
    logic           jog_select;
    logic           motor_heat_trip;
    logic           extra_speed_bit;
    logic           supply_unit_run_enable;
    logic           panel_mode_lockout;
    logic           pid_enable;
    logic           brake_open_done;
    logic           external_operation;
    logic           vf_control_switch;
    logic           output_shutoff_input;
    logic           start_self_hold;
    logic           trip_clear_input;
    logic           panel_network_switch;
    logic           external_network_switch;
    logic           command_source_switch;
  } ipm_func_s;

  typedef struct packed {
    ipm_speed_src_e src;
    logic [3:0]     preset_index;
  } ipm_speed_s;

endpackage : ipm_pkg

// ==== verilog/ipm_pin_filter.sv ====
// Two-flop synchroniser and stability filter for one input terminal.
`timescale 1ns/1ps
module ipm_pin_filter #(
  parameter int FILTER = ipm_pkg::FILTER_CYC
) (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic pin_raw,
  output logic      level_q
);

  localparam int CNT_W = $clog2(FILTER + 1);

  logic             meta_q;
  logic             sync_q;
  logic [CNT_W-1:0] cnt_q;

  initial begin
    if (FILTER < 1) begin
      $error("FILTER must be at least one cycle.");
    end
  end

  // The filtered level follows the pin only after FILTER stable cycles.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_q  <= 1'b0;
      sync_q  <= 1'b0;
      cnt_q   <= '0;
      level_q <= 1'b0;
    end else begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      if (sync_q == level_q) begin
        cnt_q <= '0;
      end else if (cnt_q == CNT_W'(FILTER - 1)) begin
        cnt_q   <= '0;
        level_q <= sync_q;
      end else begin
        cnt_q <= cnt_q + CNT_W'(1);
      end
    end
  end

endmodule : ipm_pin_filter

// ==== verification/ipm_mapper_chk.sv ====
// Concurrent checker of the input pin function mapper ports.
`timescale 1ns/1ps
module ipm_mapper_chk #(
  parameter int NUM_PINS = ipm_pkg::NUM_PINS
) (
  input wire logic                pclk,
  input wire logic                presetn,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire logic [NUM_PINS-1:0] pin_in,
  input wire ipm_pkg::ipm_func_s  func,
  input wire ipm_pkg::ipm_speed_s speed
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic       setup_w;
  logic       wr_w;
  logic       sel_w;
  logic [4:0] quiet_q;
  assign setup_w = psel && !penable;
  assign wr_w    = setup_w && pwrite;
  assign sel_w   = wr_w && paddr <= ipm_pkg::OFS_CLEAR_PIN && paddr[1:0] == 2'h0;
  // Counts cycles with steady terminals and no bus traffic.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) quiet_q <= 5'h00;
    else if ($changed(pin_in) || psel) quiet_q <= 5'h00;
    else if (quiet_q != 5'h1F) quiet_q <= quiet_q + 5'h01;
  end
  ////////////////////////////////////////////////////////////////////////////
  AST_READY_AFTER_SETUP: assert property (setup_w |=> pready)
    else $error("no ready after setup");
  AST_READY_ONE: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  AST_READY_CAUSE: assert property (pready |-> $past(setup_w))
    else $error("ready without setup");
  AST_ERR_WITH_READY: assert property (pslverr |-> pready)
    else $error("error without ready");
  AST_FWD_ONLY_PIN0: assert property (
    sel_w && paddr != ipm_pkg::OFS_FORWARD_PIN && pwdata == 32'h0000003C |=> pslverr)
    else $error("forward code taken off its pin");
  AST_REV_ONLY_PIN1: assert property (
    sel_w && paddr != ipm_pkg::OFS_REVERSE_PIN && pwdata == 32'h0000003D |=> pslverr)
    else $error("reverse code taken off its pin");
  AST_BAD_CODE: assert property (sel_w && pwdata[15:0] inside {16'h0006, 16'h0009,
    16'h000B, 16'h000D, 16'h0011, 16'h0013, 16'h0044, 16'h270E} |=> pready && pslverr)
    else $error("illegal code accepted");
  AST_NONE_OK: assert property (sel_w && pwdata == 32'h0000270F |=> !pslverr)
    else $error("no-function code refused");
  AST_REMOTE_RANGE: assert property (
    wr_w && paddr == ipm_pkg::OFS_REMOTE_SEL |=> pslverr == (pwdata > 32'h2))
    else $error("remote select range wrong");
  AST_STOP_RANGE: assert property (
    wr_w && paddr == ipm_pkg::OFS_STOP_SEL |=> pslverr == (pwdata > 32'h1))
    else $error("stop select range wrong");
  AST_SETTLED: assert property (quiet_q >= 5'h10 |-> $stable(func) && $stable(speed))
    else $error("outputs move with steady inputs");
  AST_JOG_FIRST: assert property (
    func.jog_select && $past(func.jog_select) |-> speed.src == ipm_pkg::IPM_SRC_JOG)
    else $error("jog not first in priority");
endmodule : ipm_mapper_chk

bind ipm_mapper ipm_mapper_chk #(.NUM_PINS(NUM_PINS)) ipm_mapper_chk_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pin_in(pin_in), .func(func), .speed(speed));

// ==== verification/ipm_switch_bank.sv ====
// Model of the external contacts that drive the seven input terminals.
`timescale 1ns/1ps
module ipm_switch_bank (
  input  wire logic       pclk,
  input  wire logic [6:0] close_req,
  input  wire logic       bounce,
  output logic      [6:0] pin_in
);
  logic [6:0] req_q = 7'h00;
  logic [2:0] cnt_q = 3'h0;
  // Contacts follow one cycle late; when bouncing they chatter for two cycles.
  always_ff @(posedge pclk) begin
    req_q <= close_req;
    if (close_req != req_q && bounce) cnt_q <= 3'h4;
    else if (cnt_q != 3'h0) cnt_q <= cnt_q - 3'h1;
  end
  assign pin_in = (cnt_q inside {3'h2, 3'h3}) ? ~req_q : req_q;
endmodule : ipm_switch_bank

// ==== verification/testbench.sv ====
// Self-checking testbench of the input pin function mapper.
`timescale 1ns/1ps
module testbench;
  logic                pclk = 1'b0;
  logic                presetn = 1'b0;
  logic                psel = 1'b0;
  logic                penable = 1'b0;
  logic                pwrite = 1'b0;
  logic [7:0]          paddr = 8'h00;
  logic [31:0]         pwdata = 32'h0;
  logic [31:0]         prdata;
  logic                pready;
  logic                pslverr;
  logic [6:0]          close_req = 7'h00;
  logic                bounce = 1'b0;
  logic [6:0]          pin_in;
  ipm_pkg::ipm_func_s  func;
  ipm_pkg::ipm_speed_s speed;
  int                  mismatches = 0;
  int                  total_checks = 0;
  logic [31:0]         r;
  logic                e;
  logic [26:0]         o1;
  logic [26:0]         o2;

  always #20 pclk = ~pclk;

  ipm_mapper ipm_mapper_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pin_in(pin_in), .func(func), .speed(speed));
  ipm_switch_bank ipm_switch_bank_inst (.pclk(pclk), .close_req(close_req),
    .bounce(bounce), .pin_in(pin_in));

  ////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
  endtask : idle

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      report_and_stop();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic probe(input logic [15:0] c);
    apb(1'b1, 8'h08, {16'h0000, c});
    close_req[2] <= 1'b1;
    idle(20);
    o1 = func;
    close_req[2] <= 1'b0;
    idle(20);
    o2 = func;
  endtask : probe

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    logic [15:0] rv [7] = '{16'h003C, 16'h003D, 16'h0000, 16'h0001, 16'h0002,
                            16'h0018, 16'h003E};
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, 8'(4 * i), 32'h0);
      chk(r, {16'h0000, rv[i]});
    end
  endtask : t_reset

  task automatic t_codes();
    logic [15:0] ok [21] = '{16'h0000, 16'h0001, 16'h0002, 16'h0003, 16'h0004,
      16'h0005, 16'h0007, 16'h0008, 16'h000A, 16'h000C, 16'h000E, 16'h000F, 16'h0010,
      16'h0012, 16'h0018, 16'h0019, 16'h003E, 16'h0041, 16'h0042, 16'h0043, 16'h270F};
    logic [31:0] bad [15] = '{32'h6, 32'h9, 32'hB, 32'hD, 32'h11, 32'h13, 32'h1A, 32'h3B,
      32'h3C, 32'h3D, 32'h3F, 32'h40, 32'h44, 32'h270E, 32'h10000};
    foreach (ok[i]) begin
      apb(1'b1, 8'h08, {16'h0000, ok[i]});
      chk(e, 1'b0);
      apb(1'b0, 8'h08, 32'h0);
      chk(r, {16'h0000, ok[i]});
    end
    foreach (bad[i]) begin
      apb(1'b1, 8'h08, bad[i]);
      chk(e, 1'b1);
      apb(1'b0, 8'h08, 32'h0);
      chk(r, 32'h0000270F);
    end
    apb(1'b1, 8'h00, 32'h3D);
    chk(e, 1'b1);
    apb(1'b1, 8'h04, 32'h3C);
    chk(e, 1'b1);
    apb(1'b1, 8'h04, 32'h3D);
    chk(e, 1'b0);
    apb(1'b0, 8'h2C, 32'h0);
    chk(e, 1'b1);
    apb(1'b1, 8'h24, 32'h1);
    chk(e, 1'b1);
  endtask : t_codes

  task automatic t_funcs();
    logic [15:0] c [20] = '{16'h0, 16'h1, 16'h2, 16'h3, 16'h4, 16'h5, 16'h7, 16'h8,
      16'hA, 16'hC, 16'hE, 16'hF, 16'h10, 16'h12, 16'h18, 16'h19, 16'h3E, 16'h41, 16'h42,
      16'h43};
    int b [20] = '{24, 23, 22, 16, 15, 14, 13, 12, 11, 10, 9, 8, 7, 6, 5, 4, 3, 2, 1, 0};
    foreach (c[i]) begin
      probe(c[i]);
      chk(o1, (c[i] == 16'h7) ? 0 : 32'h1 << b[i]);
      chk(o2, (c[i] == 16'h7) ? 32'h2000 : 0);
      chk(o1[4:0], (b[i] < 5) ? 32'h1 << b[i] : 0);
    end
  endtask : t_funcs

  task automatic t_modes();
    apb(1'b1, ipm_pkg::OFS_REMOTE_SEL, 32'h1);
    probe(16'h0);
    chk(o1, 32'h200000);
    apb(1'b1, ipm_pkg::OFS_REMOTE_SEL, 32'h2);
    probe(16'h1);
    chk(o1, 32'h100000);
    probe(16'h2);
    chk(o1, 32'h80000);
    apb(1'b1, ipm_pkg::OFS_REMOTE_SEL, 32'h3);
    chk(e, 1'b1);
    apb(1'b1, ipm_pkg::OFS_REMOTE_SEL, 32'h0);
    apb(1'b1, ipm_pkg::OFS_STOP_SEL, 32'h1);
    probe(16'h0);
    chk(o1, 32'h40000);
    probe(16'h3);
    chk(o1, 32'h20000);
    apb(1'b1, ipm_pkg::OFS_STOP_SEL, 32'h2);
    chk(e, 1'b1);
    apb(1'b1, ipm_pkg::OFS_STOP_SEL, 32'h0);
  endtask : t_modes

  task automatic t_prio();
    bounce <= 1'b1;
    apb(1'b1, 8'h08, 32'hE);
    apb(1'b1, 8'h0C, 32'h5);
    close_req[4:2] <= 3'b111;
    idle(20);
    chk(speed.src, ipm_pkg::IPM_SRC_JOG);
    apb(1'b0, ipm_pkg::OFS_PIN_STATUS, 32'h0);
    chk(r, 32'h0000001C);
    apb(1'b0, ipm_pkg::OFS_FUNC_STATUS, 32'h0);
    chk(r, 32'h00404200);
    close_req[3] <= 1'b0;
    idle(20);
    chk(speed, {ipm_pkg::IPM_SRC_PRESET, 4'h4});
    close_req[4] <= 1'b0;
    idle(20);
    chk(speed.src, ipm_pkg::IPM_SRC_PID);
    apb(1'b1, 8'h08, 32'h5);
    close_req[3:2] <= 2'b10;
    idle(20);
    chk(func.jog_select, 1'b1);
    close_req[3:2] <= 2'b01;
    idle(20);
    chk(func.jog_select, 1'b1);
    close_req[3:2] <= 2'b00;
    idle(20);
    chk(func, 0);
  endtask : t_prio

  task automatic t_rerun_reset();
    presetn <= 1'b0;
    idle(2);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(func, 0);
    apb(1'b0, 8'h08, 32'h0);
    chk(r, 32'h00000000);
    apb(1'b0, 8'h0C, 32'h0);
    chk(r, 32'h00000001);
  endtask : t_rerun_reset

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    idle(4);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset();
    t_codes();
    t_funcs();
    t_modes();
    t_prio();
    t_rerun_reset();
    report_and_stop();
  end
endmodule : testbench
